// file: hw/sfcf_fetch.sv
// Purpose: boot check and automatic fast-read code fetch from serial flash
// Assumes: one outstanding fetch; processor waits for ready before next
// Notes:   clock mode 0, flash select active low, sclk made by a divider
// What this block does
// - single mode burst opens with select low, opcode 0x0B, 24-bit address.
// - one dummy byte follows the address before any data capture.
// - single mode captures each byte over eight clocks on the serial input.
// - after a full byte, pulse ready once and hand over one byte.
// - next address equal to previous plus one keeps select low, one more byte.
// - any other next address ends the burst with select high.
// - dual mode burst opens with select low, opcode 0x3B, 24-bit address.
// - dual mode captures each byte in four clocks before ready.
// - dual data phase carries two bits per clock on both data lines.
// - dual mode only allowed at the slower 30 MHz rate.
// - rate strap low selects 30 MHz, high selects 60 MHz.
// - rate strap caught at reset release and held fixed afterwards.
// - at power-up read the signature 2DFU starting at flash address 0xFFFA.
// - valid signature enables external code, fetch starting at 0x0000.
// - missing signature keeps internal code and no external fetches.
`timescale 1ns/1ps
`default_nettype none
module sfcf_fetch (
    input  wire logic                    clk_in,
    input  wire logic                    rst_b_in,
    input  wire logic                    clk_en_in,
    input  wire logic                    dual_mode_en_in,
    input  wire sfcf_pkg::sfcf_req_type  fetch_req_in,
    output logic                         fetch_take_out,
    output var  sfcf_pkg::sfcf_rsp_type  fetch_rsp_out,
    output logic                         ext_code_en_out,
    output logic                         boot_done_out,
    output logic [23:0]                  fetch_start_addr_out,
    output var  sfcf_pkg::sfcf_pins_type flash_pins_out,
    input  wire logic                    flash_io_in,
    input  wire logic                    flash_serial_in
);
    sfcf_pkg::sfcf_regs_type st_reg;
    sfcf_pkg::sfcf_regs_type st_next;
    logic [1:0]              pin_sync;
    logic                    io_s;
    logic                    di_s;
    logic [2:0]              half_div;
    logic                    tick;
    logic                    fall;
    logic                    seq_hit;
    logic [7:0]              rx_new;
    logic [7:0]              sig_byte;

    sfcf_sync i_sfcf_sync (
        .clk_in    (clk_in),
        .clk_en_in (clk_en_in),
        .pins_in   ({flash_io_in, flash_serial_in}),
        .pins_out  (pin_sync)
    );
    assign io_s = pin_sync[1];
    assign di_s = pin_sync[0];

    assign half_div = st_reg.rate_fast ? sfcf_pkg::DIV_FAST : sfcf_pkg::DIV_SLOW;
    assign tick     = (st_reg.div == 3'h0);
    assign fall     = tick && st_reg.pins.sclk;
    assign seq_hit  = (fetch_req_in.addr == 24'(st_reg.addr + sfcf_pkg::ADDR_ONE));
    assign sig_byte = 8'(sfcf_pkg::SIG_WORD >> {~st_reg.sig_idx, 3'h0});

    // no fetch taken unless external code is enabled
    assign fetch_take_out = clk_en_in && fetch_req_in.valid && st_reg.ext_en &&
                            (st_reg.state == sfcf_pkg::S_IDLE ||
                             st_reg.state == sfcf_pkg::S_HOLD);

    // dual pairs: serial input is the high bit, io line the low bit
    // single mode shifts one bit per clock from the serial input
    assign rx_new = st_reg.dual ? {st_reg.rx[5:0], di_s, io_s} : {st_reg.rx[6:0], di_s};

    always_comb begin
        st_next          = st_reg;
        st_next.rsp.ready = 1'b0;
        unique case (st_reg.state)
            sfcf_pkg::S_STRAP: begin
                // strap caught once, first enabled cycle after release
                st_next.rate_fast  = io_s;
                st_next.strap_done = 1'b1;
                // boot burst reads the signature in single mode
                st_next.boot       = 1'b1;
                st_next.sig_ok     = 1'b1;
                st_next.sig_idx    = sfcf_pkg::SIG_FIRST;
                st_next.dual       = 1'b0;
                st_next.addr       = sfcf_pkg::SIG_ADDR;
                st_next.shift      = {sfcf_pkg::OP_FAST, sfcf_pkg::SIG_ADDR, sfcf_pkg::DUMMY};
                st_next.pins       = '{sel_b: 1'b0, sclk: 1'b0, dout: sfcf_pkg::OP_FAST[7],
                                       oe: 1'b1};
                st_next.bit_cnt    = sfcf_pkg::HDR_BITS;
                st_next.div        = io_s ? sfcf_pkg::DIV_FAST : sfcf_pkg::DIV_SLOW;
                st_next.state      = sfcf_pkg::S_SEND;
            end
            sfcf_pkg::S_SEND: begin
                st_next.div = tick ? half_div : 3'(st_reg.div - 3'h1);
                if (tick) begin
                    st_next.pins.sclk = ~st_reg.pins.sclk;
                end
                // next msb goes out on the falling edge
                if (fall) begin
                    st_next.shift     = {st_reg.shift[38:0], 1'b0};
                    st_next.pins.dout = st_reg.shift[38];
                    st_next.bit_cnt   = 6'(st_reg.bit_cnt - sfcf_pkg::LAST_BIT);
                    // dummy byte is the tail of the header
                    if (st_reg.bit_cnt == sfcf_pkg::LAST_BIT) begin
                        st_next.state   = sfcf_pkg::S_RECV;
                        // four pairs per byte in dual mode
                        st_next.bit_cnt = st_reg.dual ? sfcf_pkg::DUAL_PAIRS
                                                      : sfcf_pkg::BYTE_BITS;
                        // io line turns into an input for dual data
                        st_next.pins.oe = ~st_reg.dual;
                    end
                end
            end
            sfcf_pkg::S_RECV: begin
                st_next.div = tick ? half_div : 3'(st_reg.div - 3'h1);
                if (tick) begin
                    st_next.pins.sclk = ~st_reg.pins.sclk;
                end
                // sync lag makes this the level seen at the rising edge
                if (fall) begin
                    st_next.rx      = rx_new;
                    st_next.bit_cnt = 6'(st_reg.bit_cnt - sfcf_pkg::LAST_BIT);
                    if (st_reg.bit_cnt == sfcf_pkg::LAST_BIT) begin
                        st_next.bit_cnt = sfcf_pkg::BYTE_BITS;
                        if (st_reg.boot) begin
                            st_next.sig_ok  = st_reg.sig_ok && (rx_new == sig_byte);
                            st_next.sig_idx = 2'(st_reg.sig_idx + 2'h1);
                            if (st_reg.sig_idx == sfcf_pkg::SIG_LAST) begin
                                st_next.boot       = 1'b0;
                                st_next.boot_done  = 1'b1;
                                st_next.ext_en     = st_reg.sig_ok && (rx_new == sig_byte);
                                st_next.start_addr = sfcf_pkg::START_ADDR;
                                st_next.pins.sel_b = 1'b1;
                                st_next.pins.oe    = 1'b0;
                                st_next.pend       = 1'b0;
                                st_next.gap        = sfcf_pkg::GAP_LOAD;
                                st_next.state      = sfcf_pkg::S_GAP;
                            end
                        end else begin
                            st_next.rsp   = '{ready: 1'b1, data: rx_new};
                            st_next.state = sfcf_pkg::S_HOLD;
                        end
                    end
                end
            end
            sfcf_pkg::S_HOLD: begin
                if (fetch_take_out) begin
                    st_next.addr = fetch_req_in.addr;
                    if (seq_hit) begin
                        st_next.bit_cnt = st_reg.dual ? sfcf_pkg::DUAL_PAIRS
                                                      : sfcf_pkg::BYTE_BITS;
                        st_next.div     = half_div;
                        st_next.state   = sfcf_pkg::S_RECV;
                    end else begin
                        st_next.pins.sel_b = 1'b1;
                        st_next.pins.oe    = 1'b0;
                        st_next.pend       = 1'b1;
                        st_next.gap        = sfcf_pkg::GAP_LOAD;
                        st_next.state      = sfcf_pkg::S_GAP;
                    end
                end
            end
            sfcf_pkg::S_GAP, sfcf_pkg::S_IDLE: begin
                // select high time kept before a new burst
                st_next.gap = (st_reg.gap == 5'h00) ? 5'h00 : 5'(st_reg.gap - 5'h01);
                if (st_reg.state == sfcf_pkg::S_GAP && st_reg.gap == 5'h00) begin
                    st_next.state = sfcf_pkg::S_IDLE;
                end
                if ((st_reg.state == sfcf_pkg::S_GAP && st_reg.gap == 5'h00 && st_reg.pend) ||
                    fetch_take_out) begin
                    if (fetch_take_out) begin
                        st_next.addr = fetch_req_in.addr;
                    end
                    // dual only at the slow rate
                    st_next.dual       = dual_mode_en_in && !st_reg.rate_fast;
                    st_next.pend       = 1'b0;
                    st_next.state      = sfcf_pkg::S_SEND;
                    st_next.bit_cnt    = sfcf_pkg::HDR_BITS;
                    st_next.div        = half_div;
                    st_next.pins.sel_b = 1'b0;
                    st_next.pins.sclk  = 1'b0;
                    st_next.pins.oe    = 1'b1;
                    // dual or single opcode, then address, then dummy byte
                    st_next.shift = {st_next.dual ? sfcf_pkg::OP_DUAL : sfcf_pkg::OP_FAST,
                                     st_next.addr, sfcf_pkg::DUMMY};
                    st_next.pins.dout = st_next.shift[39];
                end
            end
            default: begin
                st_next.state = sfcf_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            st_reg       <= '0;
            st_reg.state <= sfcf_pkg::S_STRAP;
            st_reg.pins  <= '{sel_b: 1'b1, sclk: 1'b0, dout: 1'b0, oe: 1'b0};
        end else if (clk_en_in) begin
            st_reg <= st_next;
        end
    end

    assign fetch_rsp_out        = st_reg.rsp;
    assign ext_code_en_out      = st_reg.ext_en;
    assign boot_done_out        = st_reg.boot_done;
    assign fetch_start_addr_out = st_reg.start_addr;
    assign flash_pins_out       = st_reg.pins;

    // helper: rising sclk edges within one receive run
    logic [5:0] rise_cnt;
    always_ff @(posedge clk_in) begin
        if (!rst_b_in || st_reg.state != sfcf_pkg::S_RECV) begin
            rise_cnt <= 6'h00;
        end else if (clk_en_in && tick && !st_reg.pins.sclk) begin
            rise_cnt <= 6'(rise_cnt + 6'h01);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in || !clk_en_in);

    sequence s_hold_take;
        st_reg.state == sfcf_pkg::S_HOLD && fetch_take_out;
    endsequence
    sequence s_take_seq;
        s_hold_take ##0 seq_hit;
    endsequence
    sequence s_take_jump;
        s_hold_take ##0 !seq_hit;
    endsequence

    property p_open_op;
        $fell(flash_pins_out.sel_b) |->
            st_reg.shift[39:32] == (st_reg.dual ? sfcf_pkg::OP_DUAL : sfcf_pkg::OP_FAST);
    endproperty
    a_open_op: assert property (p_open_op) else $error("wrong opcode at select");
    property p_open_addr;
        $fell(flash_pins_out.sel_b) |->
            st_reg.shift[31:8] == st_reg.addr && st_reg.shift[7:0] == sfcf_pkg::DUMMY;
    endproperty
    a_open_addr: assert property (p_open_addr) else $error("bad address or dummy");
    property p_byte_clocks;
        $rose(fetch_rsp_out.ready) |->
            rise_cnt == (st_reg.dual ? sfcf_pkg::DUAL_PAIRS : sfcf_pkg::BYTE_BITS);
    endproperty
    a_byte_clocks: assert property (p_byte_clocks) else $error("wrong clocks per byte");
    property p_ready_one;
        fetch_rsp_out.ready |=> !fetch_rsp_out.ready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready longer than a cycle");
    property p_seq;
        s_take_seq |=> (!flash_pins_out.sel_b) [*2];
    endproperty
    a_seq: assert property (p_seq) else $error("select dropped on sequential fetch");
    property p_jump;
        s_take_jump |=> flash_pins_out.sel_b [*2];
    endproperty
    a_jump: assert property (p_jump) else $error("select kept on jump");
    property p_dual_lines;
        st_reg.state == sfcf_pkg::S_RECV && st_reg.dual |-> !flash_pins_out.oe;
    endproperty
    a_dual_lines: assert property (p_dual_lines) else $error("io driven in dual data");
    property p_dual_slow;
        !flash_pins_out.sel_b && st_reg.dual |-> !st_reg.rate_fast;
    endproperty
    a_dual_slow: assert property (p_dual_slow) else $error("dual at fast rate");
    property p_strap_fixed;
        st_reg.strap_done && $past(st_reg.strap_done) |-> $stable(st_reg.rate_fast);
    endproperty
    a_strap_fixed: assert property (p_strap_fixed) else $error("rate strap changed");
    property p_no_ext;
        st_reg.boot_done && !st_reg.ext_en |-> flash_pins_out.sel_b && !fetch_take_out;
    endproperty
    a_no_ext: assert property (p_no_ext) else $error("external fetch without signature");
    property p_start;
        $rose(ext_code_en_out) |-> fetch_start_addr_out == sfcf_pkg::START_ADDR;
    endproperty
    a_start: assert property (p_start) else $error("bad start address");
    property p_mode0;
        $rose(flash_pins_out.sclk) |-> $stable(flash_pins_out.dout);
    endproperty
    a_mode0: assert property (p_mode0) else $error("data moved on rising edge");
endmodule
`default_nettype wire

// file: inc/sfcf_pkg.sv
// Purpose: shared constants and types for the serial flash code fetch block
// Assumes: 200 MHz core clock, flash in clock mode 0
// Notes:   serial rates round down to whole half periods of the core clock
package sfcf_pkg;

    // core clock and serial rates
    localparam int CLK_MHZ     = 200;
    localparam int CLK_NS      = 5;
    localparam int SLOW_MHZ    = 30;
    localparam int FAST_MHZ    = 60;
    localparam int HALF_SLOW   = (CLK_MHZ + 2 * SLOW_MHZ - 1) / (2 * SLOW_MHZ);
    localparam int HALF_FAST   = (CLK_MHZ + 2 * FAST_MHZ - 1) / (2 * FAST_MHZ);
    localparam int CS_HIGH_NS  = 50;
    localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [2:0] DIV_SLOW = 3'(HALF_SLOW - 1);
    localparam logic [2:0] DIV_FAST = 3'(HALF_FAST - 1);
    localparam logic [4:0] GAP_LOAD = 5'(CS_HIGH_CYC - 1);

    // flash command framing
    localparam logic [7:0]  OP_FAST    = 8'h0B;
    localparam logic [7:0]  OP_DUAL    = 8'h3B;
    localparam logic [7:0]  DUMMY      = 8'h00;
    localparam logic [5:0]  HDR_BITS   = 6'h28;
    localparam logic [5:0]  BYTE_BITS  = 6'h08;
    localparam logic [5:0]  DUAL_PAIRS = 6'h04;
    localparam logic [5:0]  LAST_BIT   = 6'h01;

    // boot signature, ascii 2DFU
    localparam logic [23:0] SIG_ADDR   = 24'h00FFFA;
    localparam logic [31:0] SIG_WORD   = 32'h32444655;
    localparam logic [1:0]  SIG_LAST   = 2'h3;
    localparam logic [1:0]  SIG_FIRST  = 2'h0;
    localparam logic [23:0] START_ADDR = 24'h000000;
    localparam logic [23:0] ADDR_ONE   = 24'h000001;

    typedef enum logic [2:0] {
        S_STRAP = 3'b000,
        S_IDLE  = 3'b001,
        S_SEND  = 3'b010,
        S_RECV  = 3'b011,
        S_HOLD  = 3'b100,
        S_GAP   = 3'b101
    } sfcf_state_type;

    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
    } sfcf_req_type;

    typedef struct packed {
        logic       ready;
        logic [7:0] data;
    } sfcf_rsp_type;

    typedef struct packed {
        logic sel_b;
        logic sclk;
        logic dout;
        logic oe;
    } sfcf_pins_type;

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] stable;
    } sfcf_sync_type;

    typedef struct packed {
        sfcf_state_type state;
        logic           strap_done;
        logic           rate_fast;
        logic           dual;
        logic           boot;
        logic           boot_done;
        logic           ext_en;
        logic           sig_ok;
        logic           pend;
        logic [1:0]     sig_idx;
        logic [2:0]     div;
        logic [4:0]     gap;
        logic [5:0]     bit_cnt;
        logic [39:0]    shift;
        logic [7:0]     rx;
        logic [23:0]    addr;
        logic [23:0]    start_addr;
        sfcf_pins_type  pins;
        sfcf_rsp_type   rsp;
    } sfcf_regs_type;

endpackage

// file: hw/sfcf_sync.sv
// Purpose: two-stage synchroniser for the flash input pins
// Assumes: inputs are asynchronous to clk_in
// Notes:   no reset, so the strap level is already settled at reset release
`timescale 1ns/1ps
`default_nettype none
module sfcf_sync (
    input  wire logic       clk_in,
    input  wire logic       clk_en_in,
    input  wire logic [1:0] pins_in,
    output logic      [1:0] pins_out
);
    sfcf_pkg::sfcf_sync_type st_reg;
    sfcf_pkg::sfcf_sync_type st_next;

    always_comb begin
        st_next        = st_reg;
        st_next.meta   = pins_in;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge clk_in) begin
        if (clk_en_in) begin
            st_reg <= st_next;
        end
    end

    assign pins_out = st_reg.stable;
endmodule
`default_nettype wire

// file: verif/sfcf_flash_model.sv
// Purpose: behavioural serial flash holding firmware bytes
// Assumes: clock mode 0, fast read 0x0B or dual read 0x3B only
// Notes:   the serial line shows the inverse of its last bit on release
`timescale 1ns/1ps
`default_nettype none
module sfcf_flash_model (
    input  wire logic        sel_b_in,
    input  wire logic        sclk_in,
    input  wire logic        dout_in,
    input  wire logic        sig_good_in,
    output logic             serial_out,
    output logic             io_out,
    output logic             io_en_out,
    output logic [39:0]      hdr_out,
    output int               burst_cnt_out
);
    logic [5:0] rise_cnt;
    logic [7:0] cur;
    int         fall_cnt;
    int         pos;

    // image; signature bytes only when the bench asks for them
    function automatic logic [7:0] mem_byte(input logic [23:0] a, input logic sig);
        logic [31:0] word;
        word = 32'h32444655;
        if (sig && a >= 24'h00FFFA && a <= 24'h00FFFD)
            return word[31 - 8 * int'(a - 24'h00FFFA) -: 8];
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
    endfunction

    initial begin
        serial_out = 1'b0;
        io_out = 1'b0;
        io_en_out = 1'b0;
        hdr_out = '0;
        burst_cnt_out = 0;
        rise_cnt = '0;
        fall_cnt = 0;
    end

    always @(negedge sel_b_in) begin
        rise_cnt = '0;
        fall_cnt = 0;
        burst_cnt_out++;
    end

    // no stale bit survives a release
    always @(posedge sel_b_in) begin
        serial_out = ~serial_out;
        io_en_out = 1'b0;
    end

    always @(posedge sclk_in) begin
        if (sel_b_in === 1'b0 && rise_cnt < 6'h28) begin
            hdr_out = {hdr_out[38:0], dout_in};
            rise_cnt++;
        end
    end

    always @(negedge sclk_in) begin
        if (sel_b_in === 1'b0 && rise_cnt == 6'h28) begin
            pos = (hdr_out[39:32] == 8'h3B) ? fall_cnt * 2 : fall_cnt;
            cur = mem_byte(hdr_out[31:8] + 24'(pos / 8), sig_good_in);
            serial_out = cur[7 - (pos % 8)];
            if (hdr_out[39:32] == 8'h3B) begin
                io_out = cur[6 - (pos % 8)];
                io_en_out = 1'b1;
            end
            fall_cnt++;
        end
    end
endmodule
`default_nettype wire

// file: verif/spi_flash_code_fetch_tb.sv
// Purpose: self-checking bench for the flash code fetch block
// Assumes: flash model on the far side, strap as pull on shared line
// Notes:   clock enable dropped once while a burst is held open
`timescale 1ns/1ps
`default_nettype none
module spi_flash_code_fetch_tb;
    logic                    clk_in;
    logic                    rst_b_in;
    logic                    clk_en;
    logic                    dual_mode_en_in;
    logic                    strap_lvl;
    logic                    sig_good;
    logic                    take;
    logic                    ext_en;
    logic                    boot_done;
    logic                    ser;
    logic                    io_drv;
    logic                    io_en;
    logic [23:0]             start_addr;
    logic [39:0]             hdr;
    sfcf_pkg::sfcf_req_type  fetch_req;
    sfcf_pkg::sfcf_rsp_type  rsp;
    sfcf_pkg::sfcf_pins_type pins;
    int                      bursts;
    int                      num_errors;
    int                      cmp_count;
    int                      hi_run;
    int                      hi_len;
    int                      lat;
    wire logic               flash_io = pins.oe ? pins.dout : (io_en ? io_drv : strap_lvl);

    sfcf_fetch i_sfcf_fetch (
        .clk_in               (clk_in),
        .rst_b_in             (rst_b_in),
        .clk_en_in            (clk_en),
        .dual_mode_en_in      (dual_mode_en_in),
        .fetch_req_in         (fetch_req),
        .fetch_take_out       (take),
        .fetch_rsp_out        (rsp),
        .ext_code_en_out      (ext_en),
        .boot_done_out        (boot_done),
        .fetch_start_addr_out (start_addr),
        .flash_pins_out       (pins),
        .flash_io_in          (flash_io),
        .flash_serial_in      (ser)
    );

    sfcf_flash_model i_sfcf_flash_model (
        .sel_b_in      (pins.sel_b),
        .sclk_in       (pins.sclk),
        .dout_in       (pins.dout),
        .sig_good_in   (sig_good),
        .serial_out    (ser),
        .io_out        (io_drv),
        .io_en_out     (io_en),
        .hdr_out       (hdr),
        .burst_cnt_out (bursts)
    );

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic close_out;
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic [7:0] exp_byte(input logic [23:0] a);
        logic [31:0] word;
        word = 32'h32444655;
        if (sig_good && a >= 24'h00FFFA && a <= 24'h00FFFD)
            return word[31 - 8 * int'(a - 24'h00FFFA) -: 8];
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
    endfunction

    // serial clock high time, and one driver on the shared line
    always @(posedge clk_in) begin
        if (pins.sclk === 1'b1)
            hi_run <= hi_run + 1;
        else if (hi_run != 0) begin
            hi_len <= hi_run;
            hi_run <= 0;
        end
        if (pins.oe === 1'b1 && io_en === 1'b1) check(40'h1, 40'h0);
    end

    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask

    task automatic do_reset(input logic strap, input logic sig, input logic early);
        int n;
        int takes;
        takes = 0;
        tick();
        rst_b_in = 1'b0;
        strap_lvl = strap;
        sig_good = sig;
        fetch_req = '{valid: early, addr: 24'h000000};
        repeat (6) tick();
        rst_b_in = 1'b1;
        n = 0;
        while (boot_done !== 1'b1 && n < 4000) begin
            @(posedge clk_in);
            if (take === 1'b1) takes++;
            n++;
        end
        #1;
        check(40'(boot_done), 40'h1);
        check(hdr, {8'h0B, 24'h00FFFA, 8'h00});
        check(40'(ext_en), 40'(sig));
        check(40'(start_addr), 40'h0);
        if (early) begin
            n = bursts;
            repeat (200) begin
                @(posedge clk_in);
                if (take === 1'b1) takes++;
            end
            #1 fetch_req.valid = 1'b0;
            check(40'(takes), 40'h0);
            check(40'(bursts - n), 40'h0);
        end
    endtask

    task automatic fetch(input logic [23:0] a, input logic fresh);
        int n;
        int b0;
        b0 = bursts;
        fetch_req = '{valid: 1'b1, addr: a};
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (take !== 1'b1 && n < 100);
        #1 fetch_req.valid = 1'b0;
        lat = 0;
        while (rsp.ready !== 1'b1 && lat < 3000) begin
            @(posedge clk_in);
            lat++;
        end
        check(40'(rsp.ready), 40'h1);
        check(40'(rsp.data), 40'(exp_byte(a)));
        check(40'(bursts - b0), 40'(fresh));
        @(posedge clk_in);
        check(40'(rsp.ready), 40'h0);
        #1;
    endtask

    // frozen block must neither take a jump nor end the held burst
    task automatic t_freeze;
        int t;
        t = 0;
        clk_en = 1'b0;
        fetch_req = '{valid: 1'b1, addr: 24'h000100};
        repeat (20) begin
            tick();
            if (take === 1'b1) t++;
        end
        check(40'(t), 40'h0);
        check(40'(pins.sel_b), 40'h0);
        fetch_req.valid = 1'b0;
        clk_en = 1'b1;
    endtask

    task automatic t_single;
        dual_mode_en_in = 1'b0;
        fetch(24'h000000, 1'b1);
        check(hdr, {8'h0B, 24'h000000, 8'h00});
        fetch(24'h000001, 1'b0);
        check(40'(lat >= 60 && lat <= 80), 40'h1);
        check(40'(hi_len), 40'h4);
        fetch(24'h000002, 1'b0);
        t_freeze();
        fetch(24'h000100, 1'b1);
        check(hdr, {8'h0B, 24'h000100, 8'h00});
        fetch(24'hFFFFFF, 1'b1);
        fetch(24'h000000, 1'b0);
    endtask

    task automatic t_dual;
        dual_mode_en_in = 1'b1;
        fetch(24'h001000, 1'b1);
        check(hdr, {8'h3B, 24'h001000, 8'h00});
        fetch(24'h001001, 1'b0);
        check(40'(lat >= 30 && lat <= 48), 40'h1);
        fetch(24'h000005, 1'b1);
    endtask

    task automatic t_fast;
        do_reset(1'b1, 1'b1, 1'b0);
        dual_mode_en_in = 1'b1;
        fetch(24'h000010, 1'b1);
        check(hdr, {8'h0B, 24'h000010, 8'h00});
        fetch(24'h000011, 1'b0);
        check(40'(hi_len), 40'h2);
        strap_lvl = 1'b0;
        fetch(24'h000200, 1'b1);
        check(40'(hi_len), 40'h2);
    endtask

    initial begin
        rst_b_in = 1'b0;
        clk_en = 1'b1;
        dual_mode_en_in = 1'b0;
        strap_lvl = 1'b0;
        sig_good = 1'b0;
        fetch_req = '0;
        num_errors = 0;
        cmp_count = 0;
        hi_run = 0;
        hi_len = 0;
        do_reset(1'b0, 1'b1, 1'b0);
        t_single();
        t_dual();
        t_fast();
        do_reset(1'b0, 1'b0, 1'b1);
        close_out();
    end

    // well above the longest expected run
    initial begin
        #400000;
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
